/* File: hw/crm_regs.svh */
`ifndef CRM_REGS_SVH
`define CRM_REGS_SVH

`define CRM_IDX_RECHARGE 8'h07
`define CRM_IDX_MONITOR 8'h10
`define CRM_IDX_IRQ_STATUS 8'h20
`define CRM_IDX_IRQ_ENABLE 8'h21
`define CRM_IDX_IRQ_CLEAR 8'h22
`define CRM_ADDR_RECHARGE 12'h01c
`define CRM_ADDR_MONITOR 12'h040
`define CRM_ADDR_IRQ_STATUS 12'h080
`define CRM_ADDR_IRQ_ENABLE 12'h084
`define CRM_ADDR_IRQ_CLEAR 12'h088
`define CRM_RECHARGE_RESET 2'h1
`define CRM_DATA_W 32
`define CRM_ADDR_W 12
`define CRM_LANE_W 8
`define CRM_LANE0 0
`define CRM_RECHARGE_W 2
`define CRM_MON_W 8
`define CRM_MON_RESET 8'h00

`endif

/* File: hw/crm_pkg.sv */
package crm_pkg;
    typedef struct packed {
        logic term_below;
        logic bat_above_short;
        logic trickle_on;
        logic hot;
        logic charge_loop_released;
        logic input_limit_released;
        logic input_valid;
        logic cv_phase;
    } crm_monitor_s;

    typedef enum logic [1:0] {
        CRM_DROP_50MV,
        CRM_DROP_100MV,
        CRM_DROP_150MV,
        CRM_DROP_200MV
    } crm_drop_e;
endpackage : crm_pkg

/* File: hw/crm_charger_regs.sv */
// Operation
// - Two-bit recharge drop select field, low bits
// - Recharge register resets to 0x01
// - Bit 7 shows termination comparator
// - Bit 6 shows battery short comparator
// - Bit 2 shows input limit released
// - Bit 1 shows input validity
// - Bit 0 shows constant voltage phase
`timescale 1ns/1ns
`include "crm_regs.svh"

// One sticky status bit; set beats clear in one cycle
module crm_sticky_bit (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_set,
    input wire logic i_clear,
    output logic o_status
);
    logic status_ff;

    wire nxt_status = i_set | (status_ff & ~i_clear);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            status_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    assign o_status = status_ff;
endmodule : crm_sticky_bit

// Software register with write enable and reset value
module crm_field_reg #(
    parameter int WIDTH = `CRM_LANE_W,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_wr,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic [WIDTH-1:0] o_value
);
    logic [WIDTH-1:0] value_ff;

    if (WIDTH < 1) begin : g_width_check
        $error("crm_field_reg: WIDTH must be at least one");
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            value_ff <= RESET;
        end else if (i_wr) begin
            value_ff <= i_wdata;
        end
    end

    assign o_value = value_ff;
endmodule : crm_field_reg

// Full address compare for one register slot
module crm_addr_hit #(
    parameter int ADDR_W = `CRM_ADDR_W,
    parameter logic [ADDR_W-1:0] MATCH = '0
) (
    input wire logic [ADDR_W-1:0] i_paddr,
    output logic o_hit
);
    assign o_hit = i_paddr == MATCH;
endmodule : crm_addr_hit

module crm_charger_regs
    import crm_pkg::*;
#(
    parameter int DATA_W = `CRM_DATA_W,
    parameter int ADDR_W = `CRM_ADDR_W
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    input wire logic [DATA_W/`CRM_LANE_W-1:0] i_pstrb,
    input wire logic i_charge_mode,
    input wire crm_monitor_s i_monitor,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output crm_drop_e o_recharge_drop_select,
    output logic o_irq
);
    localparam int LANE_W = `CRM_LANE_W;
    localparam int MON_W = `CRM_MON_W;
    localparam int DROP_W = `CRM_RECHARGE_W;

    // Map and lane decode assume one 32-bit word per register
    if (DATA_W != `CRM_DATA_W) begin : g_data_w_check
        $error("crm_charger_regs: only a 32-bit data bus is served");
    end
    if (ADDR_W < `CRM_ADDR_W) begin : g_addr_w_check
        $error("crm_charger_regs: ADDR_W too narrow for the register map");
    end
    if (MON_W > LANE_W) begin : g_mon_w_check
        $error("crm_charger_regs: monitor word must fit in byte lane 0");
    end

    logic [DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [DROP_W-1:0] recharge_q;
    logic [MON_W-1:0] irq_enable_q;
    logic [MON_W-1:0] irq_status;
    crm_monitor_s monitor_ff;
    crm_monitor_s mon_prev_ff;
    crm_monitor_s mon_idle;
    logic irq_ff;
    logic hit_rch;
    logic hit_mon;
    logic hit_sts;
    logic hit_ena;
    logic hit_clr;

    // No wait state: pready rises in the first access cycle
    wire bus_setup = i_psel && !i_penable;
    wire bus_write = bus_setup && i_pwrite;
    wire bus_read = bus_setup && !i_pwrite;
    wire lane0_on = i_pstrb[`CRM_LANE0];

    // Full compare, so aliases of a register answer with an error
    crm_addr_hit #(
        .ADDR_W(ADDR_W),
        .MATCH(ADDR_W'(`CRM_ADDR_RECHARGE))
    ) u_hit_rch (
        .i_paddr(i_paddr),
        .o_hit(hit_rch)
    );

    crm_addr_hit #(
        .ADDR_W(ADDR_W),
        .MATCH(ADDR_W'(`CRM_ADDR_MONITOR))
    ) u_hit_mon (
        .i_paddr(i_paddr),
        .o_hit(hit_mon)
    );

    crm_addr_hit #(
        .ADDR_W(ADDR_W),
        .MATCH(ADDR_W'(`CRM_ADDR_IRQ_STATUS))
    ) u_hit_sts (
        .i_paddr(i_paddr),
        .o_hit(hit_sts)
    );

    crm_addr_hit #(
        .ADDR_W(ADDR_W),
        .MATCH(ADDR_W'(`CRM_ADDR_IRQ_ENABLE))
    ) u_hit_ena (
        .i_paddr(i_paddr),
        .o_hit(hit_ena)
    );

    crm_addr_hit #(
        .ADDR_W(ADDR_W),
        .MATCH(ADDR_W'(`CRM_ADDR_IRQ_CLEAR))
    ) u_hit_clr (
        .i_paddr(i_paddr),
        .o_hit(hit_clr)
    );

    wire mapped = hit_rch | hit_mon | hit_sts | hit_ena | hit_clr;
    wire unmapped = !mapped;

    // Writes land at the setup edge; a low lane 0 strobe drops them
    wire wr_ok = bus_write && mapped && lane0_on;
    wire wr_rch = wr_ok && hit_rch;
    wire wr_ena = wr_ok && hit_ena;
    wire wr_clr = wr_ok && hit_clr;
    // Monitor and status get no write strobe at all
    wire wr_mon_dropped = wr_ok && hit_mon;
    wire [LANE_W-1:0] wdata_lane0 = i_pwdata[LANE_W-1:0];
    wire [DROP_W-1:0] wdata_drop = wdata_lane0[DROP_W-1:0];
    wire [MON_W-1:0] wdata_mon = wdata_lane0[MON_W-1:0];

    // Outside charge mode the flags mean nothing; hold them low
    assign mon_idle = `CRM_MON_RESET;
    wire crm_monitor_s nxt_monitor = i_charge_mode ? i_monitor : mon_idle;
    wire [MON_W-1:0] mon_bits = monitor_ff;
    wire [MON_W-1:0] mon_prev_bits = mon_prev_ff;

    // Any change of a live flag in charge mode is an event
    wire [MON_W-1:0] mode_mask = {MON_W{i_charge_mode}};
    wire [MON_W-1:0] events = (mon_bits ^ mon_prev_bits) & mode_mask;
    wire [MON_W-1:0] clr_bits = wr_clr ? wdata_mon : '0;
    // Set beats clear when both land in one cycle
    wire [MON_W-1:0] nxt_irq_status = (irq_status & ~clr_bits) | events;
    wire [MON_W-1:0] irq_pending = nxt_irq_status & irq_enable_q;
    wire nxt_irq = |irq_pending;

    // Upper bits of every register read as zero
    wire [DATA_W-1:0] rd_rch = DATA_W'(recharge_q);
    wire [DATA_W-1:0] rd_mon = DATA_W'(mon_bits);
    wire [DATA_W-1:0] rd_sts = DATA_W'(irq_status);
    wire [DATA_W-1:0] rd_ena = DATA_W'(irq_enable_q);
    // Clear register is write-only and reads back as zero
    wire [DATA_W-1:0] rd_data =
        hit_rch ? rd_rch :
        hit_mon ? rd_mon :
        hit_sts ? rd_sts :
        hit_ena ? rd_ena : '0;
    wire [DATA_W-1:0] nxt_prdata = bus_read ? rd_data : '0;
    wire nxt_pready = bus_setup;
    wire nxt_pslverr = bus_setup && unmapped;

    crm_field_reg #(
        .WIDTH(DROP_W),
        .RESET(`CRM_RECHARGE_RESET)
    ) u_recharge (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_wr(wr_rch),
        .i_wdata(wdata_drop),
        .o_value(recharge_q)
    );

    crm_field_reg #(
        .WIDTH(MON_W),
        .RESET(`CRM_MON_RESET)
    ) u_irq_enable (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_wr(wr_ena),
        .i_wdata(wdata_mon),
        .o_value(irq_enable_q)
    );

    for (genvar b = 0; b < MON_W; b++) begin : g_status
        crm_sticky_bit u_bit (
            .i_sys_clk(i_sys_clk),
            .i_resetn(i_resetn),
            .i_set(events[b]),
            .i_clear(clr_bits[b]),
            .o_status(irq_status[b])
        );
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            prdata_ff <= '0;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= nxt_pready;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Bit order in the struct fixes bits 7..0 of the monitor word
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            monitor_ff <= mon_idle;
        end else begin
            monitor_ff <= nxt_monitor;
        end
    end

    // Previous copy feeds the change detector; reads never clear it
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            mon_prev_ff <= mon_idle;
        end else begin
            mon_prev_ff <= monitor_ff;
        end
    end

    // Interrupt follows next status, one cycle after the event
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_recharge_drop_select = crm_drop_e'(recharge_q);
    assign o_irq = irq_ff;
endmodule : crm_charger_regs

/* File: testbench/crm_charger_regs_monitor.sv */
`timescale 1ns/1ns
module crm_mon
    import crm_pkg::*;
(
    input wire logic i_sys_clk, i_resetn, i_psel, i_penable, i_pwrite, i_charge_mode, o_pready,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire crm_monitor_s i_monitor,
    input wire crm_drop_e o_recharge_drop_select
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    wire rd = i_psel && !i_penable && !i_pwrite;
    wire rch = rd && i_paddr == 12'h01c;
    wire mon = rd && i_paddr == 12'h040;
    wire wr_rch = i_psel && !i_penable && i_pwrite && i_pstrb[0] && i_paddr == 12'h01c;
    wire [1:0] wr_drop = i_pwdata[1:0];
    sequence s_drop_wr; wr_rch; endsequence
    // Monitor copy lags one cycle, so demand two settled cycles
    sequence s_live; (i_charge_mode && $stable(i_monitor))[*2]; endsequence
    AST_RST: assert property ($rose(i_resetn) |-> o_recharge_drop_select == 2'h1)
        else $error("bad reset value");
    AST_RDR: assert property (rch |=> o_prdata == {30'h0, o_recharge_drop_select})
        else $error("bad field read");
    AST_MON: assert property (s_live ##0 mon |=> o_prdata[7:0] == $past(i_monitor))
        else $error("bad monitor read");
    AST_OFF: assert property ((!i_charge_mode)[*2] ##0 mon |=> o_prdata == 32'h0)
        else $error("monitor not idle");
    AST_RDY: assert property (rd |=> o_pready ##1 !o_pready) else $error("bad ready");
    AST_WRD: assert property (s_drop_wr |=> o_recharge_drop_select == $past(wr_drop))
        else $error("recharge write not taken");
endmodule : crm_mon
bind crm_charger_regs crm_mon u_mon(.*);

/* File: testbench/crm_charger_regs_tb_top.sv */
`timescale 1ns/1ns
module crm_charger_regs_tb_top import crm_pkg::*;;
    logic i_sys_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, o_pready, o_irq;
    logic i_charge_mode = 1, o_pslverr;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata;
    logic [3:0] i_pstrb = 4'hf;
    crm_monitor_s i_monitor = 0;
    crm_drop_e o_recharge_drop_select;
    int fail_count = 0, tests_run = 0, cyc = 0;
    logic last_err = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    crm_charger_regs uut(.*);
    task chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) fail_count++;
        if (g !== e) $display("MISMATCH %0t got %h exp %h", $time, g, e);
    endtask : chk
    // Reads check against d, so one call both drives and compares
    task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, ad, d};
        @(posedge i_sys_clk) i_penable <= 1;
        do @(posedge i_sys_clk); while (o_pready !== 1);
        if (!w) chk(o_prdata, d);
        last_err = o_pslverr;
        {i_psel, i_penable} <= 0;
        @(posedge i_sys_clk);
    endtask : xfer
    task conclude;
        $display("%0d checks %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    always @(posedge i_sys_clk) begin
        if (++cyc > 999) fail_count++;
        if (cyc > 999) conclude;
    end
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_resetn <= 1;
        xfer(0, 12'h01c, 1);
        for (int i = 0; i < 4; i++) begin
            xfer(1, 12'h01c, 32'hfffffffc | i);
            chk(o_recharge_drop_select, i);
            xfer(0, 12'h01c, i);
        end
        i_pstrb <= 4'he;
        xfer(1, 12'h01c, 0);
        i_pstrb <= 4'hf;
        xfer(0, 12'h01c, 3);
        chk(last_err, 0);
        xfer(0, 12'h0fc, 0);
        chk(last_err, 1);
        xfer(1, 12'h084, 32'hff);
        for (int k = 0; k < 2; k++) begin
            i_monitor <= k ? 8'h5a : 8'ha5;
            xfer(1, 12'h040, 0);
            xfer(0, 12'h040, k ? 8'h5a : 8'ha5);
        end
        xfer(0, 12'h080, 32'hff);
        chk(o_irq, 1);
        xfer(1, 12'h088, 32'hff);
        chk(o_irq, 0);
        xfer(0, 12'h080, 0);
        i_charge_mode <= 0;
        @(posedge i_sys_clk);
        xfer(0, 12'h040, 0);
        conclude;
    end
endmodule : crm_charger_regs_tb_top
